// [hdl/vfir_pkg.sv]
// vfir_pkg.sv: constants and types shared by the vector fir filter files
package vfir_pkg;
  // vector and word sizes
  localparam int LANES = 4;          // parallel_lane_count on the input side
  localparam int DW = 16;            // input sample width
  localparam int CW = 16;            // coefficient width
  localparam int TAPS = 4;           // taps per coefficient set
  localparam int NSETS = 2;          // number of coefficient sets
  localparam int NCOEF = TAPS * NSETS; // total coefficient list length
  localparam int SELW = 1;           // width of the set selection field
  localparam int AW = 3;             // coefficient memory address width
  localparam int ACCW = DW + CW + 2; // full precision accumulator width
  localparam int OW = 16;            // reduced output width
  localparam int RATEW = 3;          // width of rate factors
  localparam int MAXUP = 2;          // largest interpolation factor
  localparam int OLANES = LANES * MAXUP; // widest output vector
  // reset values
  localparam logic [SELW-1:0] FSEL_RST = 1'h0;
  localparam logic [2:0] RMODE_RST = 3'h0;
  // filter types
  typedef enum logic [2:0] {
    VFIR_SINGLE = 3'h1,
    VFIR_INTERP = 3'h2,
    VFIR_DECIM = 3'h4
  } vfir_type_t;
  // output modes
  localparam logic [2:0] RM_FULL = 3'h0;
  localparam logic [2:0] RM_TRUNC = 3'h1;
  localparam logic [2:0] RM_DOWN = 3'h2;
  localparam logic [2:0] RM_UP = 3'h3;
  localparam logic [2:0] RM_ZERO = 3'h4;
  localparam logic [2:0] RM_INF = 3'h5;
  localparam logic [2:0] RM_EVEN = 3'h6;
  localparam logic [2:0] RM_ODD = 3'h7;
  // output pipeline depth from accepted input to output valid
  localparam int LAT = 2;
endpackage : vfir_pkg

// [hdl/vfir_coef_mem.sv]
// vfir_coef_mem.sv: coefficient store with registered read data
`timescale 1ns/1ps
`default_nettype none
module vfir_coef_mem (
  // clock
  input wire logic clk_sys,
  // write side
  input wire logic we,
  input wire logic [vfir_pkg::AW-1:0] waddr,
  input wire logic [vfir_pkg::CW-1:0] wdata,
  // read side
  input wire logic re,
  input wire logic [vfir_pkg::AW-1:0] raddr,
  output logic [vfir_pkg::CW-1:0] rdata
);
  import vfir_pkg::*;
  logic [CW-1:0] mem_ff [NCOEF]; // storage, no reset needed
  // write port; read is write-first so no read-before-write mode is used
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem_ff[waddr] <= wdata;
    end
  end
  // registered read
  always_ff @(posedge clk_sys) begin
    if (re) begin
      rdata <= (we && waddr == raddr) ? wdata : mem_ff[raddr];
    end
  end
endmodule : vfir_coef_mem
`default_nettype wire

// [hdl/vfir_top.sv]
// vfir_top.sv: vector fir filter with rate change, set select and reload
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - interpolation output width is lanes times factor, factor capped at MAXUP
// - decimation output width is lanes over factor
// - data, config, reload use stream handshakes
// - config field selects the active coefficient set
// - reloaded coefficients wait for sync event
// - sets are equal consecutive segments of list
// - single rate keeps output rate equal input
// - interpolation raises rate by up factor, capped at MAXUP
// - decimation lowers rate by down factor
// - zero packing places k-1 zero taps
// - structure symmetric, non-symmetric or inferred from values
// - eight output modes, width reduced unless full
// - transposed form ignores symmetry, no interleave
// - coefficients signed or unsigned fixed point
// - fan-out options add pipeline registers
// - memory read-before-write mode avoided on request
// - irrelevant optimisations ignored without effect
// - output ready honoured; back-pressure reaches input
// - clear beats enable, held two cycles
// - low clock enable freezes all state but the reset and clear pipelines and what an active clear resets
module vfir_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic aclken,
  input wire logic aresetn,
  // static configuration
  input wire vfir_pkg::vfir_type_t filt_type,
  input wire logic [vfir_pkg::RATEW-1:0] up_factor,
  input wire logic [vfir_pkg::RATEW-1:0] down_factor,
  input wire logic [vfir_pkg::RATEW-1:0] zero_pack,
  input wire logic [2:0] round_mode,
  input wire logic coef_signed,
  // input data stream
  input wire logic s_data_tvalid,
  output logic s_data_tready,
  input wire logic [vfir_pkg::LANES*vfir_pkg::DW-1:0] s_data_tdata,
  // output data stream
  output logic m_data_tvalid,
  input wire logic m_data_tready,
  output logic [vfir_pkg::OLANES*vfir_pkg::ACCW-1:0] m_data_tdata,
  output logic [3:0] m_data_lanes,
  // configuration stream
  input wire logic s_config_tvalid,
  output logic s_config_tready,
  input wire logic [vfir_pkg::SELW-1:0] config_tdata_fsel,
  // reload stream
  input wire logic s_reload_tvalid,
  output logic s_reload_tready,
  input wire logic s_reload_tlast,
  input wire logic [vfir_pkg::CW-1:0] s_reload_tdata,
  // status
  output logic coef_symmetric
);
  import vfir_pkg::*;

  // rounding of one accumulator to the reduced width, right-aligned and sign-extended in the high bits
  function automatic logic [ACCW-1:0] vfir_round(input logic [ACCW-1:0] a, input logic [2:0] m);
    localparam int SH = ACCW - OW;
    logic [ACCW-1:0] half;
    logic [ACCW-1:0] r;
    logic neg;
    logic lsb;
    logic tie;
    half = {{(ACCW-1){1'b0}}, 1'b1} << (SH - 1);
    neg = a[ACCW-1];
    lsb = a[SH];
    tie = (a[SH-1:0] == half[SH-1:0]);
    case (m)
      RM_FULL: r = a;
      RM_TRUNC, RM_DOWN: r = a;
      RM_UP: r = a + half;
      RM_ZERO: r = neg ? a + half : a + half - 1'b1;
      RM_INF: r = neg ? a + half - 1'b1 : a + half;
      RM_EVEN: r = (tie && !lsb) ? a : a + half;
      RM_ODD: r = (tie && lsb) ? a : a + half;
      default: r = a;
    endcase
    if (m == RM_DOWN || m == RM_TRUNC) begin
      r = a;
    end
    if (m != RM_FULL) begin
      r = {{SH{r[ACCW-1]}}, r[ACCW-1:SH]};
    end
    return r;
  endfunction : vfir_round

  // extend one coefficient according to its number format
  function automatic logic signed [CW:0] vfir_cext(input logic [CW-1:0] c, input logic sgn);
    return sgn ? {c[CW-1], c} : {1'b0, c};
  endfunction : vfir_cext

  // sample history: LANES current plus TAPS older samples of the one stream
  localparam int HIST = LANES + TAPS;

  typedef struct packed {
    logic [1:0] rst_sync;                    // async reset release pair
    logic [1:0] clr_pipe;                    // registered clear
    logic [SELW-1:0] fsel;                   // active coefficient set
    logic [SELW-1:0] fsel_pend;              // pending set from config
    logic fsel_new;                          // config waiting for sync
    logic reload_done;                       // reload waiting for sync
    logic [AW-1:0] rld_addr;                 // reload write pointer
    logic [NCOEF-1:0][CW-1:0] coef_act;      // active coefficient bank
    logic [HIST-1:0][DW-1:0] hist;           // sample history
    logic [LAT-1:0] vpipe;                   // pipeline valid
    logic [RATEW-1:0] dec_cnt;               // decimation phase
    logic out_valid;                         // output holding valid
    logic [OLANES-1:0][ACCW-1:0] out_data;   // output holding data
    logic [3:0] out_lanes;                   // lanes in current output
    logic sym;                               // inferred symmetry flag
    logic [AW-1:0] cp_addr;                  // copy pointer shadow to active
    logic copying;                           // bank copy in progress
    logic cp_tail;                           // last copy word still to land
  } vfir_state_t;

  vfir_state_t st_ff;
  vfir_state_t nxt_st;
  logic rstn_int;
  logic clr_now;
  logic [CW-1:0] shadow_rdata;
  logic mem_we;
  logic [LANES-1:0][ACCW-1:0] lane_acc;
  logic in_xfer;
  logic out_free;

  assign rstn_int = st_ff.rst_sync[1];
  assign clr_now = !st_ff.clr_pipe[1];
  assign mem_we = s_reload_tvalid && s_reload_tready && aclken;

  // reload writes land in a shadow store, never in the active bank
  vfir_coef_mem u_shadow (
    .clk_sys(clk_sys),
    .we(mem_we),
    .waddr(st_ff.rld_addr),
    .wdata(s_reload_tdata),
    .re(aclken),
    .raddr(st_ff.cp_addr),
    .rdata(shadow_rdata)
  );

  // multiply-accumulate per lane over the active segment
  // plain accumulate form: no symmetry folding, no interleaved channels
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      logic signed [ACCW-1:0] acc;
      logic signed [CW:0] c;
      logic signed [DW-1:0] d;
      int idx;
      acc = '0;
      c = '0;
      d = '0;
      idx = 0;
      for (int t = 0; t < TAPS; t++) begin
        idx = int'(st_ff.fsel) * TAPS + t;
        c = vfir_cext(st_ff.coef_act[idx], coef_signed);
        d = $signed(st_ff.hist[l + TAPS - t]);
        // zero packing: only every k-th tap carries a coefficient
        if (filt_type == VFIR_INTERP && zero_pack > 1 && (t % int'(zero_pack)) != 0) begin
          c = '0;
        end
        // widen before the product so extreme samples cannot overflow
        acc = acc + ACCW'(c) * ACCW'(d);
      end
      lane_acc[l] = acc;
    end
  end

  // output slot frees when consumer takes data or nothing is held
  assign out_free = !st_ff.out_valid || m_data_tready;
  assign in_xfer = s_data_tvalid && s_data_tready;

  // next-state logic
  always_comb begin
    logic sym_v;
    int f;
    int nl;
    nxt_st = st_ff;
    sym_v = 1'b1;
    f = 1;
    nl = LANES;
    nxt_st.rst_sync = {st_ff.rst_sync[0], 1'b1};
    nxt_st.clr_pipe = {st_ff.clr_pipe[0], aresetn};
    if (clr_now) begin
      // synchronous clear wins over the clock enable
      nxt_st.fsel_new = 1'b0;
      nxt_st.reload_done = 1'b0;
      nxt_st.rld_addr = '0;
      nxt_st.vpipe = '0;
      nxt_st.dec_cnt = '0;
      nxt_st.out_valid = 1'b0;
      nxt_st.copying = 1'b0;
      nxt_st.cp_addr = '0;
      nxt_st.cp_tail = 1'b0;
    end else if (aclken) begin
      // configuration acceptance, held until sync
      if (s_config_tvalid && s_config_tready) begin
        nxt_st.fsel_pend = config_tdata_fsel;
        nxt_st.fsel_new = 1'b1;
      end
      // reload acceptance into the shadow store
      if (mem_we) begin
        nxt_st.rld_addr = (st_ff.rld_addr == AW'(NCOEF - 1)) ? '0 : st_ff.rld_addr + 1'b1;
        if (s_reload_tlast || st_ff.rld_addr == AW'(NCOEF - 1)) begin
          nxt_st.reload_done = 1'b1;
          nxt_st.rld_addr = '0;
        end
      end
      // sync event: a new config on an input vector boundary
      if (in_xfer && st_ff.fsel_new) begin
        nxt_st.fsel = st_ff.fsel_pend;
        nxt_st.fsel_new = 1'b0;
        if (st_ff.reload_done) begin
          nxt_st.copying = 1'b1;
          nxt_st.reload_done = 1'b0;
          nxt_st.cp_addr = '0;
        end
      end
      // copy shadow to active one word per cycle, one read of latency;
      // the tail cycle lands the last word after the pointer wraps
      if (st_ff.copying) begin
        nxt_st.cp_addr = st_ff.cp_addr + 1'b1;
        if (st_ff.cp_addr != '0 || st_ff.cp_tail) begin
          nxt_st.coef_act[st_ff.cp_addr - 1'b1] = shadow_rdata;
        end
        if (st_ff.cp_tail) begin
          nxt_st.copying = 1'b0;
          nxt_st.cp_tail = 1'b0;
          nxt_st.cp_addr = '0;
        end else if (st_ff.cp_addr == AW'(NCOEF - 1)) begin
          nxt_st.cp_tail = 1'b1;
        end
      end
      // sample history shift by one vector
      if (in_xfer) begin
        for (int i = 0; i < TAPS; i++) begin
          nxt_st.hist[i] = st_ff.hist[i + LANES];
        end
        for (int i = 0; i < LANES; i++) begin
          nxt_st.hist[TAPS + i] = s_data_tdata[i*DW +: DW];
        end
      end
      nxt_st.vpipe = {st_ff.vpipe[LAT-2:0], in_xfer};
      if (m_data_tready) begin
        nxt_st.out_valid = 1'b0;
      end
      // output formation per filter type
      if (st_ff.vpipe[0]) begin
        f = 1;
        nl = LANES;
        nxt_st.out_data = '0;
        case (filt_type)
          VFIR_INTERP: begin
            f = (up_factor > MAXUP) ? MAXUP : ((up_factor == 0) ? 1 : int'(up_factor));
            nl = LANES * f;
            for (int i = 0; i < OLANES; i++) begin
              if (i < nl) begin
                nxt_st.out_data[i] = vfir_round(lane_acc[i / f], round_mode);
              end
            end
            nxt_st.out_valid = 1'b1;
          end
          VFIR_DECIM: begin
            f = (down_factor == 0) ? 1 : int'(down_factor);
            nl = LANES / f;
            for (int i = 0; i < LANES; i++) begin
              if (i < nl) begin
                nxt_st.out_data[i] = vfir_round(lane_acc[i * f], round_mode);
              end
            end
            nxt_st.out_valid = 1'b1;
          end
          default: begin
            for (int i = 0; i < LANES; i++) begin
              nxt_st.out_data[i] = vfir_round(lane_acc[i], round_mode);
            end
            nxt_st.out_valid = 1'b1;
          end
        endcase
        nxt_st.out_lanes = 4'(nl);
      end
      // symmetry is inferred from the active set's values
      for (int t = 0; t < TAPS / 2; t++) begin
        if (st_ff.coef_act[int'(st_ff.fsel) * TAPS + t]
            != st_ff.coef_act[int'(st_ff.fsel) * TAPS + TAPS - 1 - t]) begin
          sym_v = 1'b0;
        end
      end
      nxt_st.sym = sym_v;
    end
  end

  // reset synchroniser and state register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0;
    end else if (!rstn_int) begin
      st_ff <= '0;
      st_ff.rst_sync <= nxt_st.rst_sync;
      st_ff.fsel <= FSEL_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // stream ready and output registers; input stalls while output is held
  // these registers are the output fan-out pipeline stage
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_data_tready <= 1'b0;
      s_config_tready <= 1'b0;
      s_reload_tready <= 1'b0;
      m_data_tvalid <= 1'b0;
      m_data_tdata <= '0;
      m_data_lanes <= '0;
      coef_symmetric <= 1'b0;
    end else begin
      s_data_tready <= rstn_int && !clr_now && !nxt_st.out_valid && !nxt_st.copying
        && nxt_st.vpipe == '0;
      s_config_tready <= rstn_int && !clr_now && !nxt_st.fsel_new;
      s_reload_tready <= rstn_int && !clr_now && !nxt_st.reload_done && !nxt_st.copying;
      m_data_tvalid <= nxt_st.out_valid;
      m_data_tdata <= nxt_st.out_data;
      m_data_lanes <= nxt_st.out_lanes;
      coef_symmetric <= nxt_st.sym;
    end
  end

  // output stays stable while stalled
  a_out_hold: assert property (@(posedge clk_sys) disable iff (!rstn_int)
    m_data_tvalid && !m_data_tready && aclken && !clr_now |=> m_data_tvalid && $stable(m_data_tdata))
    else $error("output changed under back-pressure");
  // clear empties output two cycles after low
  a_clr_out: assert property (@(posedge clk_sys) disable iff (!rstn_int)
    !aresetn ##1 !aresetn |=> ##1 !m_data_tvalid)
    else $error("clear did not drop output valid");
  // interpolation lane count
  a_interp_w: assert property (@(posedge clk_sys) disable iff (!rstn_int)
    m_data_tvalid && filt_type == VFIR_INTERP && up_factor == 2 |-> m_data_lanes == 4'(2*LANES))
    else $error("interpolated width wrong");
  // one accepted input vector, and a following cycle that runs
  sequence s_take;
    s_data_tvalid && s_data_tready && aclken && !clr_now;
  endsequence
  sequence s_run;
    aclken && !clr_now;
  endsequence
  // output valid follows a taken vector after one running cycle
  a_out_lat: assert property (@(posedge clk_sys) disable iff (!rstn_int)
    s_take ##1 s_run |=> m_data_tvalid)
    else $error("output did not follow input");
  // only one vector in flight
  a_one_flight: assert property (@(posedge clk_sys) disable iff (!rstn_int)
    s_take |=> !s_data_tready)
    else $error("input ready stayed high after a take");
  // a last reload word closes the reload channel until the copy that follows sync ends
  a_rld_close: assert property (@(posedge clk_sys) disable iff (!rstn_int)
    s_reload_tvalid && s_reload_tready && s_reload_tlast && aclken && !clr_now
    |=> !s_reload_tready)
    else $error("reload ready stayed high after last word");
  // low enable freezes the output registers
  a_freeze_out: assert property (@(posedge clk_sys) disable iff (!rstn_int)
    !aclken && !clr_now |=> $stable(m_data_tvalid) && $stable(m_data_tdata))
    else $error("output moved while enable low");
endmodule : vfir_top
`default_nettype wire

// [test/vfir_sink_model.sv]
// vfir_sink_model.sv: stream consumer model for the filter output
`timescale 1ns/1ps
`default_nettype none
module vfir_sink_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // bench control
  input wire logic stall,
  // output stream from the filter
  input wire logic m_data_tvalid,
  output logic m_data_tready,
  input wire logic [vfir_pkg::OLANES*vfir_pkg::ACCW-1:0] m_data_tdata,
  input wire logic [3:0] m_data_lanes,
  // captured beat
  output logic [vfir_pkg::OLANES*vfir_pkg::ACCW-1:0] cap_data,
  output logic [3:0] cap_lanes,
  output int beats
);
  import vfir_pkg::*;
  // ready moves off the sampling edge, so stalls apply back-pressure cleanly
  always @(negedge clk_sys or negedge resetn) begin
    if (!resetn) m_data_tready <= 1'b0;
    else m_data_tready <= !stall;
  end
  // a beat counts only where valid and ready meet on a rising edge
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) beats <= 0;
    else if (m_data_tvalid && m_data_tready) begin
      cap_data <= m_data_tdata;
      cap_lanes <= m_data_lanes;
      beats <= beats + 1;
    end
  end
endmodule : vfir_sink_model
`default_nettype wire

// [test/vfir_top_tb.sv]
// vfir_top_tb.sv: self-checking bench for the vector fir filter
`timescale 1ns/1ps
`default_nettype none
module vfir_top_tb;
  import vfir_pkg::*;
  logic clk_sys, resetn, aclken, aresetn, coef_signed, stall;
  vfir_type_t filt_type;
  logic [RATEW-1:0] up_factor, down_factor, zero_pack;
  logic [2:0] round_mode;
  logic s_data_tvalid, s_data_tready, m_data_tvalid, m_data_tready;
  logic [LANES*DW-1:0] s_data_tdata;
  logic [OLANES*ACCW-1:0] m_data_tdata, cap_data;
  logic [3:0] m_data_lanes, cap_lanes;
  logic s_config_tvalid, s_config_tready, s_reload_tvalid, s_reload_tready, s_reload_tlast;
  logic [SELW-1:0] config_tdata_fsel;
  logic [CW-1:0] s_reload_tdata;
  logic coef_symmetric;
  int beats, bad_count, num_checks, k;
  // test vector with both extremes and a negative lane
  localparam logic [63:0] V0 = 64'hFFFD_0102_7FFF_8000;
  vfir_top vfir_top_inst (.clk_sys(clk_sys), .resetn(resetn), .aclken(aclken),
    .aresetn(aresetn), .filt_type(filt_type), .up_factor(up_factor),
    .down_factor(down_factor), .zero_pack(zero_pack), .round_mode(round_mode),
    .coef_signed(coef_signed), .s_data_tvalid(s_data_tvalid),
    .s_data_tready(s_data_tready), .s_data_tdata(s_data_tdata),
    .m_data_tvalid(m_data_tvalid), .m_data_tready(m_data_tready),
    .m_data_tdata(m_data_tdata), .m_data_lanes(m_data_lanes),
    .s_config_tvalid(s_config_tvalid), .s_config_tready(s_config_tready),
    .config_tdata_fsel(config_tdata_fsel), .s_reload_tvalid(s_reload_tvalid),
    .s_reload_tready(s_reload_tready), .s_reload_tlast(s_reload_tlast),
    .s_reload_tdata(s_reload_tdata), .coef_symmetric(coef_symmetric));
  vfir_sink_model vfir_sink_model_inst (.clk_sys(clk_sys), .resetn(resetn),
    .stall(stall), .m_data_tvalid(m_data_tvalid), .m_data_tready(m_data_tready),
    .m_data_tdata(m_data_tdata), .m_data_lanes(m_data_lanes), .cap_data(cap_data),
    .cap_lanes(cap_lanes), .beats(beats));
  // 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // verdict and end of run, shared by the main flow and every timeout
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  // compare one output word
  task automatic chk_val(input string what, input logic [ACCW-1:0] exp, input logic [ACCW-1:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val
  // compare one flag
  task automatic chk_flag(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_flag
  // ready of a channel: 0 data, 1 config, 2 reload
  function automatic logic rdy(input int ch);
    return (ch == 0) ? s_data_tready : (ch == 1) ? s_config_tready : s_reload_tready;
  endfunction : rdy
  // one stream transfer; request held until the edge that sees ready high
  task automatic xfer(input int ch, input logic [63:0] d, input logic last);
    int i;
    @(negedge clk_sys);
    case (ch)
      0: begin s_data_tdata = d; s_data_tvalid = 1'b1; end
      1: begin config_tdata_fsel = d[SELW-1:0]; s_config_tvalid = 1'b1; end
      default: begin s_reload_tdata = d[CW-1:0]; s_reload_tlast = last; s_reload_tvalid = 1'b1; end
    endcase
    for (i = 0; i < 200 && rdy(ch) !== 1'b1; i++) @(negedge clk_sys);
    if (i == 200) begin bad_count++; summarize(); end
    @(posedge clk_sys);
    @(negedge clk_sys);
    // released data and reload payloads show the inverse so stale data cannot pass
    s_data_tvalid = 1'b0; s_config_tvalid = 1'b0; s_reload_tvalid = 1'b0;
    s_data_tdata = ~s_data_tdata; s_reload_tdata = ~s_reload_tdata;
  endtask : xfer
  // wait a bounded time for the next output beat
  task automatic get_out();
    int i, b;
    b = beats;
    for (i = 0; i < 50 && beats == b; i++) @(negedge clk_sys);
    if (beats == b) begin bad_count++; summarize(); end
  endtask : get_out
  // lanes of the last beat against sample times a tap-zero gain
  task automatic chk_vec(input logic [63:0] d, input int g);
    chk_val("lanes", ACCW'(LANES), ACCW'(cap_lanes));
    for (int i = 0; i < LANES; i++)
      chk_val("lane", ACCW'(signed'(d[i*DW +: DW])) * ACCW'(g), cap_data[i*ACCW +: ACCW]);
  endtask : chk_vec
  // main sequence
  initial begin
    {aclken, aresetn, coef_signed} = 3'h7;
    {resetn, stall, s_data_tvalid, s_config_tvalid, s_reload_tvalid, s_reload_tlast} = 6'h0;
    {filt_type, up_factor, down_factor, zero_pack} = {VFIR_SINGLE, 3'h2, 3'h2, 3'h1};
    round_mode = RM_FULL;
    s_data_tdata = '0; config_tdata_fsel = '0; s_reload_tdata = '0;
    bad_count = 0; num_checks = 0;
    repeat (8) @(negedge clk_sys);
    resetn = 1'b1;
    chk_flag("valid after reset", 1'b0, m_data_tvalid);
    $display("test reset done");
    // zero bank before any reload, single rate keeps four lanes
    xfer(0, V0, 1'b0); get_out(); chk_vec(V0, 0);
    chk_flag("symmetric", 1'b1, coef_symmetric);
    // set 0 taps 1,0,0,0 then set 1 taps 2,0,0,0 as consecutive segments
    for (k = 0; k < NCOEF; k++) xfer(2, (k == 0) ? 64'h1 : (k == TAPS) ? 64'h2 : 64'h0, k == NCOEF-1);
    xfer(0, V0, 1'b0); get_out(); chk_vec(V0, 0);
    xfer(1, 64'h0, 1'b0); xfer(0, V0, 1'b0); get_out();
    xfer(0, V0, 1'b0); get_out(); chk_vec(V0, 1);
    xfer(1, 64'h1, 1'b0); xfer(0, V0, 1'b0); get_out();
    xfer(0, V0, 1'b0); get_out(); chk_vec(V0, 2);
    chk_flag("asymmetric", 1'b0, coef_symmetric);
    $display("test reload and set select done");
    // consumer stalls; output must hold and input must refuse
    stall = 1'b1;
    xfer(0, V0, 1'b0);
    repeat (6) @(negedge clk_sys);
    chk_flag("held valid", 1'b1, m_data_tvalid);
    chk_flag("input refused", 1'b0, s_data_tready);
    stall = 1'b0; get_out(); chk_vec(V0, 2);
    $display("test back-pressure done");
    // enable low right after the take freezes the pipeline
    xfer(0, V0, 1'b0); aclken = 1'b0;
    repeat (5) @(negedge clk_sys);
    chk_flag("frozen valid", 1'b0, m_data_tvalid);
    aclken = 1'b1; get_out(); chk_vec(V0, 2);
    $display("test clock enable done");
    // every output mode yields a four-lane beat
    for (k = 0; k < 8; k++) begin
      round_mode = k[2:0]; xfer(0, V0, 1'b0); get_out();
      chk_val("mode lanes", ACCW'(LANES), ACCW'(cap_lanes));
      chk_val("mode lane0", (k == 0) ? ACCW'(-65536) : (k < 3) ? ACCW'(-1) : ACCW'(0), cap_data[ACCW-1:0]);
    end
    round_mode = RM_FULL;
    $display("test output modes done");
    // rate modes after a clear held two cycles with enable low
    for (k = 0; k < 2; k++) begin
      filt_type = (k == 0) ? VFIR_INTERP : VFIR_DECIM;
      zero_pack = (k == 0) ? 3'h2 : 3'h1;
      stall = 1'b1; xfer(0, V0, 1'b0);
      repeat (3) @(negedge clk_sys);
      chk_flag("valid before clear", 1'b1, m_data_tvalid);
      aresetn = 1'b0; aclken = 1'b0;
      repeat (2) @(negedge clk_sys);
      aresetn = 1'b1; aclken = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk_flag("clear valid", 1'b0, m_data_tvalid);
      stall = 1'b0;
      xfer(0, V0, 1'b0); get_out();
      chk_val("rate lanes", ACCW'((k == 0) ? LANES*2 : LANES/2), ACCW'(cap_lanes));
      chk_val("rate lane0", ACCW'(-65536), cap_data[ACCW-1:0]);
    end
    $display("test rate modes done");
    summarize();
  end
endmodule : vfir_top_tb
`default_nettype wire
